/* File: design/pcrs_map.svh */
// constants of the program counter and return stack block
// assumes: included by the core module by bare name
// Function
// - program counter is 21 bits, byte addressed, spanning 2 Mbytes.
// - fetch beyond implemented memory returns all zeros, a no-operation.
// - every reset loads the counter with address 0000h.
// - high interrupt loads 0008h, low interrupt loads 0018h.
// - top four program words are configuration, copied to registers on reset.
// - words ascend low byte first; only words one to three are kept.
// - low byte directly accessible; high and upper bytes only via latches.
// - writing the low byte loads high and upper bytes from the latches.
// - reading the low byte copies high and upper bytes into the latches.
// - counter bit 0 stays zero; sequential fetch advances by 2.
// - call, relative call, goto and branch load the whole counter directly.
// - calls and interrupts push, returns pop; latches stay untouched.
// - stack is 31 entries of 21 bits with a 5-bit pointer.
// - push increments the pointer first, then writes the return address.
// - pop loads the counter from the selected entry, then decrements.
// - pointer is zero after every reset; zero has no entry behind it.
// - flags show stack full or overflowed, and stack underflowed.
// - only the top entry and the pointer are readable and writable.
// - program fetch and data access use separate buses concurrently.
// - full sets on 31st push; with fault reset enabled, push then reset.
// - without fault reset, pointer saturates at 31 and never overwrites.
// - pop at zero loads zero, sets underflow, keeps zero; may reset.
// - full is bit 7, underflow bit 6; cleared by software or power-on.
`ifndef PCRS_MAP_SVH
`define PCRS_MAP_SVH
`define PCRS_PC_W 21
`define PCRS_RESET_VEC 21'h000000
`define PCRS_HIGH_VEC 21'h000008
`define PCRS_LOW_VEC 21'h000018
`define PCRS_PC_STEP 21'h000002
`define PCRS_SP_RESET 5'h00
`define PCRS_SP_MAX 5'h1f
`define PCRS_SP_LAST_FREE 5'h1e
`define PCRS_FULL_BIT 7
`define PCRS_UNF_BIT 6
`define PCRS_CFG_WORDS 2'h3
`define PCRS_CFG_AREA 21'h000008
`endif

/* File: design/pcrs_pkg.sv */
// types shared by the program counter and return stack block
// assumes: constants come from pcrs_map.svh
package pcrs_pkg;
  typedef enum logic [0:0] {
    PCRS_LOAD = 1'b0,
    PCRS_RUN = 1'b1
  } pcrs_state_t;
endpackage

/* File: design/pcrs_core.sv */
// program counter, hard vectors, configuration copy and return stack
// assumes: request strobes come from the core decoder on clk, at most
// one sequencing request per cycle; program memory answers combinationally
`timescale 1ns/1ps
`include "pcrs_map.svh"
module pcrs_core #(
  parameter int PROG_BYTES = 32768
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic softReset,
  input wire logic stackFaultResetEnable,
  input wire logic fetchAdvance,
  input wire logic jumpLoad,
  input wire logic callPush,
  input wire logic intHigh,
  input wire logic intLow,
  input wire logic retPop,
  input wire logic [20:0] jumpTarget,
  input wire logic pcLowWrite,
  input wire logic pcLowRead,
  input wire logic [7:0] pcLowWriteData,
  input wire logic highLatchWrite,
  input wire logic upperLatchWrite,
  input wire logic [7:0] latchWriteData,
  input wire logic topWriteLow,
  input wire logic topWriteHigh,
  input wire logic topWriteUpper,
  input wire logic [7:0] topWriteData,
  input wire logic spWrite,
  input wire logic [7:0] spWriteData,
  input wire logic [15:0] progRdData,
  input wire logic [15:0] cfgRdData,
  output logic [20:0] fetchAddr,
  output logic [15:0] instrWord,
  output logic [20:0] cfgAddr,
  output logic [7:0] pcLowByte,
  output logic [7:0] pcHighLatch,
  output logic [4:0] pcUpperLatch,
  output logic [20:0] topEntry,
  output logic [7:0] returnStackPointer,
  output logic [15:0] configWordFirst,
  output logic [15:0] configWordSecond,
  output logic [15:0] configWordThird,
  output logic coreReady,
  output logic stackResetPulse
);

  // memory must be whole words, hold the config area and fit 2 Mbytes
  if (PROG_BYTES % 8 != 0 || PROG_BYTES < 64 || PROG_BYTES > 2097152) begin : g_chk
    $error("pcrs_core: PROG_BYTES out of range");
  end

  localparam logic [21:0] MEM_TOP = 22'(PROG_BYTES);

  pcrs_pkg::pcrs_state_t state_reg;
  logic [20:0] pc_reg;
  logic [4:0] sp_reg;
  logic full_reg;
  logic unf_reg;
  logic [7:0] highLatch_reg;
  logic [4:0] upperLatch_reg;
  logic [1:0] cfgIdx_reg;
  logic [15:0] cfgWord_reg [0:2];
  logic [15:0] instr_reg;
  logic [20:0] top_reg;
  logic stackReset_reg;
  logic [20:0] stackMem [1:31]; // no entry behind pointer zero

  function automatic logic [20:0] cfgByteAddr(input logic [1:0] idx);
    cfgByteAddr = 21'(MEM_TOP) - `PCRS_CFG_AREA + {18'h00000, idx, 1'b0};
  endfunction

  // request resolution: pushes outrank pops, pops outrank counter writes
  wire run = clkEn & (state_reg == pcrs_pkg::PCRS_RUN) & ~softReset;
  wire anyPushReq = callPush | intHigh | intLow;
  wire stackReq = anyPushReq | retPop;
  wire spZero = sp_reg == `PCRS_SP_RESET;
  wire spFull = sp_reg == `PCRS_SP_MAX;
  wire doPush = run & anyPushReq;
  wire doPop = run & retPop & ~anyPushReq;
  wire pushWrite = doPush & ~spFull;
  wire fullSet = doPush & (sp_reg >= `PCRS_SP_LAST_FREE);
  wire pushWrap = fullSet & ~spFull & stackFaultResetEnable;
  wire popFault = doPop & spZero;
  wire faultReset = pushWrap | (popFault & stackFaultResetEnable);
  wire anyReset = clkEn & (softReset | faultReset);
  wire selHigh = doPush & intHigh & ~faultReset;
  wire selLow = doPush & intLow & ~intHigh & ~faultReset;
  wire selCall = doPush & callPush & ~intHigh & ~intLow & ~faultReset;
  wire selPop = doPop & ~faultReset;
  wire selLowWr = run & pcLowWrite & ~stackReq;
  wire selJump = run & jumpLoad & ~stackReq & ~pcLowWrite;
  wire selAdv = run & fetchAdvance & ~stackReq & ~pcLowWrite & ~jumpLoad;
  wire [4:0] spInc = sp_reg + 5'h01;
  wire [20:0] topNow = spZero ? 21'h000000 : stackMem[sp_reg];
  wire pcBeyond = {1'b0, pc_reg} >= MEM_TOP;
  wire tosTouch = run & ~stackReq & ~spZero & ~spWrite;

  // next counter value; bit 0 forced low keeps word alignment
  wire [20:0] pcLowWrValue = {upperLatch_reg, highLatch_reg, pcLowWriteData[7:1], 1'b0};
  wire [20:0] pcNextRaw =
    anyReset ? `PCRS_RESET_VEC :
    selHigh ? `PCRS_HIGH_VEC :
    selLow ? `PCRS_LOW_VEC :
    selCall ? jumpTarget :
    selPop ? topNow : // pop at zero gives zero
    selLowWr ? pcLowWrValue :
    selJump ? jumpTarget :
    selAdv ? pc_reg + `PCRS_PC_STEP :
    pc_reg;
  wire [20:0] pcNext = {pcNextRaw[20:1], 1'b0};

  // pointer: saturates when full, stays at zero on underflow
  wire [4:0] spNext =
    anyReset ? `PCRS_SP_RESET :
    doPush ? (spFull ? sp_reg : spInc) :
    doPop ? (spZero ? sp_reg : sp_reg - 5'h01) :
    (run & spWrite) ? spWriteData[4:0] :
    sp_reg;

  // hardware set wins over a software clear in the same cycle
  wire fullNext = (clkEn & fullSet) |
    (full_reg & ~(run & spWrite & ~spWriteData[`PCRS_FULL_BIT]));
  wire unfNext = (clkEn & popFault) |
    (unf_reg & ~(run & spWrite & ~spWriteData[`PCRS_UNF_BIT]));

  // sequencing state; flags live apart since only power-on or software clears them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= pcrs_pkg::PCRS_LOAD;
      pc_reg <= `PCRS_RESET_VEC;
      sp_reg <= `PCRS_SP_RESET;
      stackReset_reg <= 1'b0;
    end else if (clkEn) begin
      pc_reg <= pcNext;
      sp_reg <= spNext;
      stackReset_reg <= faultReset;
      if (anyReset) begin
        state_reg <= pcrs_pkg::PCRS_LOAD;
      end else if (state_reg == pcrs_pkg::PCRS_LOAD && cfgIdx_reg == `PCRS_CFG_WORDS) begin
        state_reg <= pcrs_pkg::PCRS_RUN;
      end
    end
  end

  // stack flags, cleared only by power-on or software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      full_reg <= 1'b0;
      unf_reg <= 1'b0;
    end else if (clkEn) begin
      full_reg <= fullNext;
      unf_reg <= unfNext;
    end
  end

  // latches: low byte read copies the counter, push and pop leave them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      highLatch_reg <= 8'h00;
      upperLatch_reg <= 5'h00;
    end else if (clkEn) begin
      if (anyReset) begin
        highLatch_reg <= 8'h00;
        upperLatch_reg <= 5'h00;
      end else if (run & highLatchWrite) begin
        highLatch_reg <= latchWriteData;
      end else if (run & pcLowRead) begin
        highLatch_reg <= pc_reg[15:8];
      end
      if (!anyReset && run && upperLatchWrite) begin
        upperLatch_reg <= latchWriteData[4:0];
      end else if (!anyReset && run && pcLowRead && !highLatchWrite) begin
        upperLatch_reg <= pc_reg[20:16];
      end
    end
  end

  // configuration copy, one word per cycle from the top of memory
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgIdx_reg <= 2'h0;
      cfgWord_reg[0] <= 16'h0000;
      cfgWord_reg[1] <= 16'h0000;
      cfgWord_reg[2] <= 16'h0000;
    end else if (clkEn) begin
      if (anyReset) begin
        cfgIdx_reg <= 2'h0;
      end else if (state_reg == pcrs_pkg::PCRS_LOAD) begin
        // low byte sits at the lower address; the fourth word is never stored
        if (cfgIdx_reg != `PCRS_CFG_WORDS) begin
          cfgWord_reg[cfgIdx_reg] <= cfgRdData;
          cfgIdx_reg <= cfgIdx_reg + 2'h1;
        end
      end
    end
  end

  // stack storage: push writes after the increment, top bytes by software
  always_ff @(posedge clk) begin
    if (clkEn) begin
      if (pushWrite) begin
        stackMem[spInc] <= pc_reg;
      end else if (tosTouch) begin
        // relies on software masking interrupts around this access
        if (topWriteLow) begin
          stackMem[sp_reg][7:0] <= topWriteData;
        end
        if (topWriteHigh) begin
          stackMem[sp_reg][15:8] <= topWriteData;
        end
        if (topWriteUpper) begin
          stackMem[sp_reg][20:16] <= topWriteData[4:0];
        end
      end
    end
  end

  // fetch data lands one cycle after the address; unimplemented reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_reg <= 16'h0000;
      top_reg <= 21'h000000;
    end else if (clkEn) begin
      instr_reg <= pcBeyond ? 16'h0000 : progRdData;
      top_reg <= topNow;
    end
  end

  // outputs straight from flops, except cfgAddr, which adds twice the index to the config base
  assign fetchAddr = pc_reg;
  assign instrWord = instr_reg;
  assign cfgAddr = cfgByteAddr(cfgIdx_reg);
  assign pcLowByte = pc_reg[7:0];
  assign pcHighLatch = highLatch_reg;
  assign pcUpperLatch = upperLatch_reg;
  assign topEntry = top_reg;
  assign returnStackPointer = {full_reg, unf_reg, 1'b0, sp_reg};
  assign configWordFirst = cfgWord_reg[0];
  assign configWordSecond = cfgWord_reg[1];
  assign configWordThird = cfgWord_reg[2];
  assign coreReady = state_reg == pcrs_pkg::PCRS_RUN;
  assign stackResetPulse = stackReset_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_reset_vector: assert property (clkEn && softReset |=> pc_reg == 21'h000000 && !coreReady)
    else $error("soft reset did not vector to zero");
  chk_high_vector: assert property (selHigh |=> pc_reg == 21'h000008)
    else $error("high interrupt vector wrong");
  chk_low_vector: assert property (selLow |=> pc_reg == 21'h000018)
    else $error("low interrupt vector wrong");
  chk_pc_aligned: assert property (pc_reg[0] == 1'b0)
    else $error("counter misaligned");
  chk_seq_advance: assert property (selAdv |=> pc_reg == $past(pc_reg) + 21'h000002)
    else $error("sequential fetch did not add two");
  chk_push_order: assert property (pushWrite && !faultReset |=>
      sp_reg == $past(sp_reg) + 5'h01 ##1 topEntry == $past(pc_reg, 2))
    else $error("push did not increment then write");
  chk_full_saturate: assert property (doPush && spFull |=> sp_reg == 5'h1f && full_reg)
    else $error("full stack pointer moved");
  chk_wrap_reset: assert property (pushWrap |=> sp_reg == 5'h00 && full_reg && stackResetPulse)
    else $error("overflow reset misbehaved");
  chk_underflow_zero: assert property (popFault |=> pc_reg == 21'h000000 && sp_reg == 5'h00
      && unf_reg)
    else $error("underflow handling wrong");
  chk_latch_load: assert property (selLowWr |=>
      pc_reg[20:8] == {$past(upperLatch_reg), $past(highLatch_reg)})
    else $error("low byte write ignored the latches");
  chk_nop_beyond: assert property (clkEn && pcBeyond |=> instrWord == 16'h0000)
    else $error("unimplemented fetch not zero");
  chk_flag_sticky: assert property (full_reg && !(clkEn && spWrite) |=> full_reg)
    else $error("full flag cleared without software");

  // direct loads, latch copies and stack edges
  chk_call_target: assert property (selCall |=>
      pc_reg == ($past(jumpTarget) & 21'h1ffffe))
    else $error("call did not load its target");
  chk_jump_direct: assert property (selJump |=>
      pc_reg == ($past(jumpTarget) & 21'h1ffffe))
    else $error("jump did not load its target");
  chk_pop_order: assert property (selPop && !spZero |=>
      pc_reg == ($past(topNow) & 21'h1ffffe) && sp_reg == $past(sp_reg) - 5'h01)
    else $error("pop did not load then decrement");
  chk_latch_copy: assert property (run && pcLowRead && !anyReset
      && !highLatchWrite && !upperLatchWrite |=>
      {upperLatch_reg, highLatch_reg, 8'h00} == ($past(pc_reg) & 21'h1fff00))
    else $error("low byte read did not copy the counter");
  chk_latch_kept: assert property ((doPush || doPop) && !anyReset && !pcLowRead
      && !highLatchWrite && !upperLatchWrite |=>
      $stable(highLatch_reg) && $stable(upperLatch_reg))
    else $error("push or pop disturbed the latches");
  chk_top_empty: assert property (clkEn && spZero |=> topEntry == 21'h000000)
    else $error("pointer zero showed a stack entry");
  chk_soft_flags: assert property (clkEn && softReset |=>
      full_reg == $past(full_reg) && unf_reg == $past(unf_reg))
    else $error("reset disturbed the stack flags");
  chk_pulse_once: assert property (stackResetPulse |=> !stackResetPulse)
    else $error("fault reset pulse longer than one cycle");
  chk_cfg_order: assert property (clkEn && !anyReset && !coreReady
      && cfgIdx_reg != 2'h3 |=> cfgAddr == $past(cfgAddr) + 21'h000002)
    else $error("configuration words not read in ascending order");

endmodule // pcrs_core

/* File: sim/pcrs_prog_mem.sv */
// partner model: program memory with separate fetch and config read ports
// assumes: combinational answers; holds a pattern even above the part's
// top, so zeroing there is left to the block itself
`timescale 1ns/1ps
module pcrs_prog_mem (
  input wire logic [20:0] fetchAddr,
  input wire logic [20:0] cfgAddr,
  output logic [15:0] progRdData,
  output logic [15:0] cfgRdData
);
  // two independent ports, read in the same cycle
  assign progRdData = fetchAddr[16:1] ^ 16'h3c5a; // never zero-filled
  assign cfgRdData = cfgAddr[16:1] ^ 16'h3c5a;
endmodule // pcrs_prog_mem

/* File: sim/tb.sv */
// self-checking bench for the program counter and return stack block
// assumes: design and partner compiled first; memory size shrunk to 256
`timescale 1ns/1ps
module tb;
  localparam int PB = 256;
  logic clk, rst_n, sfre;
  logic [10:0] stb; // strobes, one request per pulse
  logic [7:0] dat;
  logic [20:0] tgt, expPc, exStk [1:31];
  logic [31:0] rnd;
  logic [20:0] fetchAddr, cfgAddr, topEntry;
  logic [15:0] progRdData, cfgRdData, instrWord, cw1, cw2, cw3;
  logic [7:0] pcLowByte, pcHighLatch, rsp;
  logic [4:0] pcUpperLatch;
  logic coreReady, stackResetPulse;
  logic ce, srst;
  logic [2:0] tw; // top entry byte strobes: low, high, upper
  int n_fail, checked, i;

  pcrs_core #(.PROG_BYTES(PB)) u_pcrs_core (.clk(clk), .rst_n(rst_n), .clkEn(ce),
    .softReset(srst), .stackFaultResetEnable(sfre), .fetchAdvance(stb[0]),
    .jumpLoad(stb[1]), .callPush(stb[2]), .intHigh(stb[3]), .intLow(stb[4]),
    .retPop(stb[5]), .jumpTarget(tgt), .pcLowWrite(stb[6]), .pcLowRead(stb[7]),
    .pcLowWriteData(dat), .highLatchWrite(stb[8]), .upperLatchWrite(stb[9]),
    .latchWriteData(dat), .topWriteLow(tw[0]), .topWriteHigh(tw[1]),
    .topWriteUpper(tw[2]), .topWriteData(dat), .spWrite(stb[10]),
    .spWriteData(dat), .progRdData(progRdData), .cfgRdData(cfgRdData),
    .fetchAddr(fetchAddr), .instrWord(instrWord), .cfgAddr(cfgAddr),
    .pcLowByte(pcLowByte), .pcHighLatch(pcHighLatch), .pcUpperLatch(pcUpperLatch),
    .topEntry(topEntry), .returnStackPointer(rsp), .configWordFirst(cw1),
    .configWordSecond(cw2), .configWordThird(cw3), .coreReady(coreReady),
    .stackResetPulse(stackResetPulse));
  pcrs_prog_mem u_pcrs_prog_mem (.fetchAddr(fetchAddr), .cfgAddr(cfgAddr),
    .progRdData(progRdData), .cfgRdData(cfgRdData));

  // expected memory word, written out apart from the partner
  function automatic logic [15:0] memw(input logic [20:0] a);
    return {a[16:1]} ^ 16'h3c5a;
  endfunction
  // next value of the stimulus generator
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [20:0] seen, input logic [20:0] exp, input string m);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask
  // one-cycle strobe; returns just after the edge that took it
  task automatic pulse(input int b);
    @(posedge clk) stb[b] <= 1'b1;
    @(posedge clk) stb <= 11'h000;
    #1;
  endtask
  // top entry byte strobes, same timing as pulse
  task automatic tpulse(input logic [2:0] w);
    @(posedge clk) tw <= w;
    @(posedge clk) tw <= 3'h0;
    #1;
  endtask
  // bounded wait for the configuration copy; running out ends the run
  task automatic wait_ready();
    int k;
    k = 0;
    while (k < 20 && coreReady !== 1'b1) begin
      @(posedge clk) #1;
      k++;
    end
    if (coreReady !== 1'b1) begin
      n_fail++;
      final_report();
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0; sfre = 1'b0; stb = 11'h000; dat = 8'h00; tgt = 21'h000000;
    rnd = 32'hd003; n_fail = 0; checked = 0;
    ce = 1'b1;
    srst = 1'b0;
    tw = 3'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    wait_ready();
    #1;
    chk(fetchAddr, 21'h000000, "reset vector");
    chk(rsp, 8'h00, "pointer at reset");
    chk(cw1, memw(21'(PB - 8)), "config first");
    chk(cw2, memw(21'(PB - 6)), "config second");
    chk(cw3, memw(21'(PB - 4)), "config third");
    pulse(0);
    chk(fetchAddr, 21'h000002, "advance by two");
    @(posedge clk) #1;
    chk(instrWord, memw(21'h000002), "fetched word");
    // odd target beyond the implemented top: aligned, and reads zero
    tgt <= 21'(PB + 5);
    pulse(1);
    chk(fetchAddr, 21'(PB + 4), "aligned jump");
    @(posedge clk) #1;
    chk(instrWord, 21'h000000, "unimplemented reads zero");
    // latch path, random bytes
    rnd = lfsr(rnd);
    dat <= rnd[7:0];
    expPc[15:0] = {rnd[7:0], 8'h00};
    pulse(8);
    chk(pcHighLatch, expPc[15:8], "high latch write");
    rnd = lfsr(rnd);
    dat <= rnd[7:0];
    expPc[20:16] = rnd[4:0];
    pulse(9);
    chk(pcUpperLatch, expPc[20:16], "upper latch write");
    rnd = lfsr(rnd); dat <= rnd[7:0]; pulse(6);
    chk(fetchAddr, expPc | {13'h0000, rnd[7:1], 1'b0}, "low write loads");
    chk(pcLowByte, {rnd[7:1], 1'b0}, "low byte readback");
    rnd = lfsr(rnd); tgt <= rnd[20:0]; pulse(1);
    pulse(7);
    chk(pcHighLatch, tgt[15:8], "read copies high");
    chk(pcUpperLatch, tgt[20:16], "read copies upper");
    // interrupts push and vector; latches stay
    expPc = {tgt[20:1], 1'b0};
    pulse(3);
    chk(fetchAddr, 21'h000008, "high vector");
    chk(rsp, 8'h01, "pointer after push");
    @(posedge clk) #1;
    chk(topEntry, expPc, "pushed address");
    pulse(4);
    chk(fetchAddr, 21'h000018, "low vector");
    chk(pcHighLatch, tgt[15:8], "latch kept");
    pulse(5);
    chk(fetchAddr, 21'h000008, "pop inner");
    pulse(5);
    chk(fetchAddr, expPc, "pop outer");
    chk(rsp, 8'h00, "pointer back");
    pulse(5);
    chk(fetchAddr, 21'h000000, "underflow to zero");
    chk(rsp, 8'h40, "underflow flag");
    dat <= 8'h00; pulse(10);
    chk(rsp, 8'h00, "software clear");
    // fill with random calls until full, then one more
    expPc = 21'h000000;
    for (i = 1; i <= 31; i++) begin
      rnd = lfsr(rnd);
      exStk[i] = expPc;
      expPc = {rnd[20:1], 1'b0};
      tgt <= expPc;
      pulse(2);
      chk(rsp, (i == 31) ? 21'h00009f : 21'(i), "push pointer");
    end
    tgt <= 21'h000100; pulse(2);
    chk(rsp, 8'h9f, "saturated");
    for (i = 31; i >= 1; i--) begin
      pulse(5);
      chk(fetchAddr, exStk[i], "pop order");
    end
    chk(rsp, 8'h80, "full flag stays");
    // software writes the top entry, then a return takes it
    tgt <= 21'h000040;
    pulse(2);
    chk(rsp, 8'h81, "push with full kept");
    rnd = lfsr(rnd);
    dat <= rnd[7:0];
    expPc = {rnd[4:0], rnd[7:0], rnd[7:0]};
    tpulse(3'h7); // no interrupt strobes meanwhile
    @(posedge clk) #1;
    chk(topEntry, expPc, "top entry write");
    pulse(5);
    chk(fetchAddr, {expPc[20:1], 1'b0}, "popped written entry");
    // clock enable low: the strobe is lost and nothing moves
    @(posedge clk) ce <= 1'b0;
    pulse(0);
    chk(fetchAddr, {expPc[20:1], 1'b0}, "frozen counter");
    @(posedge clk) ce <= 1'b1;
    dat <= 8'h00;
    pulse(10);
    chk(rsp, 8'h00, "flags cleared");
    // overflow with the fault reset enabled: push, then reset and reload
    sfre <= 1'b1;
    tgt <= 21'h000100;
    for (i = 1; i <= 30; i++) begin
      pulse(2);
    end
    chk(rsp, 8'h1e, "thirty entries");
    pulse(2);
    chk(fetchAddr, 21'h000000, "overflow reset vector");
    chk(rsp, 8'h80, "full kept, pointer zero");
    chk(stackResetPulse, 1'b1, "overflow reset pulse");
    chk(coreReady, 1'b0, "reload after overflow");
    wait_ready();
    chk(stackResetPulse, 1'b0, "pulse ends");
    chk(cw1, memw(21'(PB - 8)), "config reloaded");
    // underflow with the fault reset enabled
    pulse(5);
    chk(fetchAddr, 21'h000000, "underflow reset vector");
    chk(rsp, 8'hc0, "underflow with reset");
    chk(stackResetPulse, 1'b1, "underflow reset pulse");
    wait_ready();
    // soft reset in mid-run: counter, pointer, latches cleared, flags kept
    sfre <= 1'b0;
    tgt <= 21'h000200;
    pulse(2);
    dat <= 8'h3c;
    pulse(8);
    @(posedge clk) srst <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    #1;
    chk(fetchAddr, 21'h000000, "soft reset vector");
    chk(rsp, 8'hc0, "flags survive soft reset");
    chk(pcHighLatch, 8'h00, "latch cleared");
    chk(coreReady, 1'b0, "soft reset reloads");
    wait_ready();
    pulse(0);
    chk(fetchAddr, 21'h000002, "runs after soft reset");
    final_report();
  end
endmodule // tb
